//--- src/commutation_axis.sv
// one axis: commutation phase setup, hall calibration, step output
// assumes a single 125 MHz clock and a one-cycle register strobe port
//
// Behaviour
// - halls present: phase estimated after every reset
// - zero-phase command drives to zero outside stepper mode, loads zero
// - command argument sets drive voltage
// - positive ends motor off, negative servo on
// - hall estimate good to thirty degrees
// - distance to zero phase readable
// - armed calibration loads phase at transition outside stepper mode
// - calibration assumes sixty-degree hall spacing
// - step pulses have fifty percent duty
// - stepper mode hides auxiliary encoder
// - smoothing 1 to 16, 16 smoothest
// - profiler drives steps with ramps and slew
// - stepper mode: no filter, no position error
// - type 2 active low, -2 active high
// - step on primary, direction on secondary
// - commanded and encoder positions both readable
// - integrated amp powers up enabled unless jumper
`timescale 1ns/1ps
module commutation_axis #(
  parameter int ZP_CYCLES = axis_pkg::ZP_DRIVE_CYC,
  parameter bit INTEGRATED_AMP = 1'b1,
  parameter bit HALL_PRESENT = 1'b1
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic [7:0] i_ADDR,
  input wire logic [31:0] i_WDATA,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic i_ENC_A,
  input wire logic i_ENC_B,
  input wire logic [2:0] i_HALL,
  input wire logic i_MOTOR_OFF_JUMPER,
  output logic [31:0] o_RDATA,
  output logic [15:0] o_PRIMARY_CMD,
  output logic [15:0] o_SECONDARY_CMD,
  output logic o_AMP_ENABLE,
  output logic o_AUX_ENC_AVAIL
);
  typedef struct packed {
    logic [1:0] enc_s1;
    logic [1:0] enc_s2;
    logic [1:0] enc_q;
    logic [2:0] hall_s1;
    logic [2:0] hall_s2;
    logic jmp_s1;
    logic jmp_s2;
    logic [1:0] boot_cnt;
    logic boot_done;
    logic stepper;
    logic hall_on;
    logic cal_armed;
    logic servo_en;
    logic mt_high;
    logic [4:0] smooth;
    logic [15:0] slew;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [31:0] target;
    logic [15:0] mag;
    logic [15:0] torque;
    logic [15:0] zp_volt;
    axis_pkg::zp_state_t zp_state;
    logic [31:0] zp_cnt;
    logic [31:0] ref_pos;
    logic [31:0] enc_pos;
    logic [15:0] phase;
    logic [15:0] rate;
    logic run;
    logic dir;
    logic [axis_pkg::TICK_BITS-1:0] tick_cnt;
    logic [31:0] rdata;
    logic [15:0] prim;
    logic [15:0] sec;
    logic amp_en;
    logic aux_avail;
  } axis_st_t;
  axis_st_t s_r, s_nxt;

  logic hp_valid;
  logic [15:0] hp_mid;
  logic [15:0] hp_edge;
  logic hp_trans;
  logic sg_level;
  logic sg_step;
  logic tick;
  logic busy;
  logic step_pin;
  logic [31:0] remaining;
  logic [31:0] dist_abs;
  logic [31:0] phase_ofs;
  logic [31:0] pos_err;
  logic [1:0] enc_move;

  hall_phase u_hall (
    .i_clock(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_hall(s_r.hall_s2),
    .i_mag_cycle(s_r.mag),
    .o_valid(hp_valid),
    .o_mid_count(hp_mid),
    .o_edge_count(hp_edge),
    .o_transition(hp_trans)
  );

  step_gen u_step (
    .i_clock(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_run(s_r.run),
    .i_tick(tick),
    .i_rate(s_r.rate),
    .i_smooth(s_r.smooth),
    .o_level(sg_level),
    .o_step(sg_step)
  );

  // quadrature step: 01 up, 11 down, otherwise none
  function automatic logic [1:0] quad(input logic [1:0] o,
                                      input logic [1:0] n);
    logic [3:0] t;
    t = {o, n};
    unique case (t)
      4'h1, 4'h7, 4'he, 4'h8: quad = 2'h1;
      4'h2, 4'hb, 4'hd, 4'h4: quad = 2'h3;
      default: quad = 2'h0;
    endcase
  endfunction : quad

  // derived views of the axis state
  always_comb begin
    tick = (s_r.tick_cnt == '0);
    busy = (s_r.zp_state != axis_pkg::ZP_IDLE) || s_r.cal_armed;
    step_pin = s_r.mt_high ? sg_level : ~sg_level;
    remaining = s_r.target - s_r.ref_pos;
    dist_abs = remaining[31] ? 32'(-remaining) : remaining;
    enc_move = quad(s_r.enc_q, s_r.enc_s2);
    if (s_r.phase < (s_r.mag >> 1)) begin
      phase_ofs = 32'(-{16'h0, s_r.phase});
    end else begin
      phase_ofs = {16'h0, 16'(s_r.mag - s_r.phase)};
    end
    pos_err = s_r.stepper ? '0 : 32'(s_r.target - s_r.enc_pos);
  end

  // next state: register port, boot, init, profiler, outputs
  always_comb begin
    s_nxt = s_r;
    s_nxt.enc_s1 = {i_ENC_A, i_ENC_B};
    s_nxt.enc_s2 = s_r.enc_s1;
    s_nxt.enc_q = s_r.enc_s2;
    s_nxt.hall_s1 = i_HALL;
    s_nxt.hall_s2 = s_r.hall_s1;
    s_nxt.jmp_s1 = i_MOTOR_OFF_JUMPER;
    s_nxt.jmp_s2 = s_r.jmp_s1;
    s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    s_nxt.rdata = '0;

    // boot: pick servo state once settled, then estimate phase
    // the hall decoder output is only valid one cycle after settling
    if (s_r.boot_cnt != axis_pkg::BOOT_SETTLE) begin
      s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
      if (s_nxt.boot_cnt == axis_pkg::BOOT_SETTLE) begin
        s_nxt.servo_en = INTEGRATED_AMP && !s_r.jmp_s2;
      end
    end else if (!s_r.boot_done) begin
      s_nxt.boot_done = 1'b1;
      if (s_r.hall_on && hp_valid) begin
        s_nxt.phase = hp_mid;
      end
    end

    // encoder position and electrical phase tracking
    if (enc_move == 2'h1) begin
      s_nxt.enc_pos = s_r.enc_pos + 32'h1;
      s_nxt.phase = (16'(s_r.phase + 16'h1) == s_r.mag) ? 16'h0 :
        16'(s_r.phase + 16'h1);
    end else if (enc_move == 2'h3) begin
      s_nxt.enc_pos = s_r.enc_pos - 32'h1;
      s_nxt.phase = (s_r.phase == 16'h0) ? 16'(s_r.mag - 16'h1) :
        16'(s_r.phase - 16'h1);
    end

    // hall calibration loads the transition boundary once
    if (s_r.cal_armed && hp_trans && !s_r.stepper) begin
      s_nxt.phase = hp_edge;
      s_nxt.cal_armed = 1'b0;
    end

    // zero-phase initialisation sequence
    unique case (s_r.zp_state)
      axis_pkg::ZP_IDLE: s_nxt.zp_cnt = '0;
      axis_pkg::ZP_DRIVE: begin
        s_nxt.zp_cnt = s_r.zp_cnt + 32'h1;
        if (s_r.zp_cnt == 32'(ZP_CYCLES - 1)) begin
          s_nxt.zp_state = axis_pkg::ZP_LOAD;
        end
      end
      axis_pkg::ZP_LOAD: begin
        s_nxt.phase = 16'h0;
        s_nxt.servo_en = s_r.zp_volt[15];
        s_nxt.zp_state = axis_pkg::ZP_IDLE;
      end
    endcase

    // stepper profiler: ramp up to slew, ramp down near target
    if (s_r.stepper && s_r.run) begin
      if (tick) begin
        if (dist_abs <= {20'h0, s_r.rate[15:4]}) begin
          s_nxt.rate = (s_r.rate > s_r.decel) ?
            16'(s_r.rate - s_r.decel) : s_r.decel;
        end else if (s_r.rate < s_r.slew) begin
          s_nxt.rate = (16'(s_r.slew - s_r.rate) > s_r.accel) ?
            16'(s_r.rate + s_r.accel) : s_r.slew;
        end else begin
          s_nxt.rate = s_r.slew;
        end
      end
      if (sg_step) begin
        s_nxt.ref_pos = s_r.dir ? s_r.ref_pos - 32'h1 :
          s_r.ref_pos + 32'h1;
        if (dist_abs == 32'h1) begin
          s_nxt.run = 1'b0;
          s_nxt.rate = '0;
        end
      end
    end else if (!s_r.stepper) begin
      s_nxt.run = 1'b0;
    end

    // register writes
    if (i_WR) begin
      unique case (i_ADDR)
        axis_pkg::A_CTRL: begin
          s_nxt.stepper = i_WDATA[axis_pkg::CB_STEP];
          s_nxt.hall_on = i_WDATA[axis_pkg::CB_HALL];
          s_nxt.servo_en = i_WDATA[axis_pkg::CB_SERVO];
          if (i_WDATA[axis_pkg::CB_CAL] && !busy) begin
            s_nxt.cal_armed = 1'b1;
          end
        end
        axis_pkg::A_MOTOR_TYPE:
          s_nxt.mt_high = (i_WDATA[7:0] == axis_pkg::MT_STEP_HIGH);
        axis_pkg::A_ZERO_PHASE: begin
          if (!busy) begin
            s_nxt.zp_volt = i_WDATA[15:0];
            s_nxt.zp_state = axis_pkg::ZP_DRIVE;
          end
        end
        axis_pkg::A_SMOOTH: begin
          if (i_WDATA < {27'h0, axis_pkg::SMOOTH_MIN}) begin
            s_nxt.smooth = axis_pkg::SMOOTH_MIN;
          end else if (i_WDATA > {27'h0, axis_pkg::SMOOTH_MAX}) begin
            s_nxt.smooth = axis_pkg::SMOOTH_MAX;
          end else begin
            s_nxt.smooth = i_WDATA[4:0];
          end
        end
        axis_pkg::A_SLEW: s_nxt.slew = i_WDATA[15:0];
        axis_pkg::A_ACCEL: s_nxt.accel = i_WDATA[15:0];
        axis_pkg::A_DECEL: s_nxt.decel = i_WDATA[15:0];
        axis_pkg::A_TARGET: begin
          s_nxt.target = i_WDATA;
          s_nxt.run = s_r.stepper && (i_WDATA != s_r.ref_pos);
          s_nxt.dir = 32'(i_WDATA - s_r.ref_pos) >= 32'h80000000;
        end
        axis_pkg::A_MAG_CYCLE: s_nxt.mag = i_WDATA[15:0];
        axis_pkg::A_TORQUE: s_nxt.torque = i_WDATA[15:0];
        default: ;
      endcase
    end

    // register reads, data in the next cycle only
    if (i_RD) begin
      unique case (i_ADDR)
        axis_pkg::A_CTRL: s_nxt.rdata = {28'h0, s_r.cal_armed,
          s_r.servo_en, s_r.hall_on, s_r.stepper};
        axis_pkg::A_MOTOR_TYPE: s_nxt.rdata = s_r.mt_high ?
          {24'hffffff, axis_pkg::MT_STEP_HIGH} :
          {24'h0, axis_pkg::MT_STEP_LOW};
        axis_pkg::A_ZERO_PHASE: s_nxt.rdata = {16'h0, s_r.zp_volt};
        axis_pkg::A_SMOOTH: s_nxt.rdata = {27'h0, s_r.smooth};
        axis_pkg::A_SLEW: s_nxt.rdata = {16'h0, s_r.slew};
        axis_pkg::A_ACCEL: s_nxt.rdata = {16'h0, s_r.accel};
        axis_pkg::A_DECEL: s_nxt.rdata = {16'h0, s_r.decel};
        axis_pkg::A_TARGET: s_nxt.rdata = s_r.target;
        axis_pkg::A_MAG_CYCLE: s_nxt.rdata = {16'h0, s_r.mag};
        axis_pkg::A_TORQUE: s_nxt.rdata = {16'h0, s_r.torque};
        axis_pkg::A_STATUS: s_nxt.rdata = {27'h0, hp_valid, s_r.run,
          busy, s_r.servo_en, s_r.stepper};
        axis_pkg::A_REF_POS: s_nxt.rdata = s_r.ref_pos;
        axis_pkg::A_ENC_POS: s_nxt.rdata = s_r.enc_pos;
        axis_pkg::A_PHASE_OFS: s_nxt.rdata = phase_ofs;
        axis_pkg::A_POS_ERR: s_nxt.rdata = pos_err;
        axis_pkg::A_PHASE: s_nxt.rdata = {16'h0, s_r.phase};
        default: s_nxt.rdata = '0;
      endcase
    end

    // output pins: step/direction or drive levels
    s_nxt.aux_avail = !s_r.stepper;
    if (s_r.stepper) begin
      s_nxt.prim = step_pin ? axis_pkg::FULL_ON : axis_pkg::FULL_OFF;
      s_nxt.sec = s_r.dir ? axis_pkg::FULL_ON : axis_pkg::FULL_OFF;
      s_nxt.amp_en = 1'b1;
    end else if (s_r.zp_state == axis_pkg::ZP_DRIVE) begin
      s_nxt.prim = s_r.zp_volt;
      s_nxt.sec = axis_pkg::FULL_OFF;
      s_nxt.amp_en = 1'b1;
    end else begin
      s_nxt.prim = s_r.servo_en ? s_r.torque : axis_pkg::FULL_OFF;
      s_nxt.sec = axis_pkg::FULL_OFF;
      s_nxt.amp_en = s_r.servo_en;
    end
  end

  // all axis state registered here
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      s_r <= '0;
      s_r.hall_on <= HALL_PRESENT;
      s_r.smooth <= axis_pkg::SMOOTH_RST;
      s_r.mag <= axis_pkg::MAG_CYCLE_RST;
      s_r.zp_state <= axis_pkg::ZP_IDLE;
      s_r.aux_avail <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_RDATA = s_r.rdata;
  assign o_PRIMARY_CMD = s_r.prim;
  assign o_SECONDARY_CMD = s_r.sec;
  assign o_AMP_ENABLE = s_r.amp_en;
  assign o_AUX_ENC_AVAIL = s_r.aux_avail;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_load;
    s_r.zp_state == axis_pkg::ZP_LOAD;
  endsequence
  property p_zp_zero;
    s_load |=> (s_r.phase == 16'h0) && (s_r.zp_state == axis_pkg::ZP_IDLE);
  endproperty
  a_zp_zero: assert property (p_zp_zero) else $error("phase not zeroed");
  property p_zp_volt;
    s_r.zp_state == axis_pkg::ZP_DRIVE && !s_r.stepper |=>
      o_PRIMARY_CMD == $past(s_r.zp_volt) && o_SECONDARY_CMD == 16'h0;
  endproperty
  a_zp_volt: assert property (p_zp_volt) else $error("drive level wrong");
  property p_zp_end;
    s_load |=> s_r.servo_en == $past(s_r.zp_volt[15]);
  endproperty
  a_zp_end: assert property (p_zp_end) else $error("end state wrong");
  property p_busy;
    s_r.zp_state == axis_pkg::ZP_DRIVE && i_WR &&
      i_ADDR == axis_pkg::A_ZERO_PHASE |=> $stable(s_r.zp_volt);
  endproperty
  a_busy: assert property (p_busy) else $error("busy request taken");
  property p_cal;
    s_r.cal_armed && hp_trans && !s_r.stepper && !i_WR |=>
      !s_r.cal_armed && s_r.phase == $past(hp_edge);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration missed");
  property p_no_err;
    i_RD && i_ADDR == axis_pkg::A_POS_ERR && s_r.stepper |=> o_RDATA == 0;
  endproperty
  a_no_err: assert property (p_no_err) else $error("stepper error seen");
  property p_step_pin;
    s_r.stepper |=> o_PRIMARY_CMD == ($past(step_pin) ? 16'hffff : 16'h0);
  endproperty
  a_step_pin: assert property (p_step_pin) else $error("step pin wrong");
  property p_aux;
    s_r.stepper [*2] |-> !o_AUX_ENC_AVAIL;
  endproperty
  a_aux: assert property (p_aux) else $error("aux still offered");
endmodule : commutation_axis

//--- shared/axis_pkg.sv
// constants for one commutated or stepped motion axis
// assumes a 125 MHz core clock and the register port of commutation_axis
package axis_pkg;
  localparam int CLK_MHZ = 125;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MOTOR_TYPE = 8'h04;
  localparam logic [7:0] A_ZERO_PHASE = 8'h08;
  localparam logic [7:0] A_SMOOTH = 8'h0c;
  localparam logic [7:0] A_SLEW = 8'h10;
  localparam logic [7:0] A_ACCEL = 8'h14;
  localparam logic [7:0] A_DECEL = 8'h18;
  localparam logic [7:0] A_TARGET = 8'h1c;
  localparam logic [7:0] A_MAG_CYCLE = 8'h20;
  localparam logic [7:0] A_TORQUE = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_REF_POS = 8'h2c;
  localparam logic [7:0] A_ENC_POS = 8'h30;
  localparam logic [7:0] A_PHASE_OFS = 8'h34;
  localparam logic [7:0] A_POS_ERR = 8'h38;
  localparam logic [7:0] A_PHASE = 8'h3c;
  // control bit positions
  localparam int CB_STEP = 0;
  localparam int CB_HALL = 1;
  localparam int CB_SERVO = 2;
  localparam int CB_CAL = 3;
  // motor type codes, two's complement in eight bits
  localparam logic [7:0] MT_STEP_LOW = 8'h02;
  localparam logic [7:0] MT_STEP_HIGH = 8'hfe;
  // reset values and smoothing limits
  localparam logic [15:0] MAG_CYCLE_RST = 16'h0fa0;
  localparam logic [4:0] SMOOTH_RST = 5'h02;
  localparam logic [4:0] SMOOTH_MIN = 5'h01;
  localparam logic [4:0] SMOOTH_MAX = 5'h10;
  // timing
  localparam int ZP_DRIVE_MS = 100;
  localparam int ZP_DRIVE_CYC = ZP_DRIVE_MS * CLK_MHZ * 1000;
  localparam int TICK_BITS = 10;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;
  localparam int DECEL_SHIFT = 4;
  // one sixth of a cycle as a 16-bit fraction
  localparam logic [16:0] SIXTH_FRAC = 17'h02aab;
  localparam logic [15:0] FULL_ON = 16'hffff;
  localparam logic [15:0] FULL_OFF = 16'h0000;
  typedef enum logic [1:0] {ZP_IDLE, ZP_DRIVE, ZP_LOAD} zp_state_t;
endpackage : axis_pkg

//--- src/hall_phase.sv
// hall sector decode, phase estimate and transition detection
// assumes hall inputs already pass two flip-flops in the parent
`timescale 1ns/1ps
module hall_phase (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [2:0] i_hall,
  input wire logic [15:0] i_mag_cycle,
  output logic o_valid,
  output logic [15:0] o_mid_count,
  output logic [15:0] o_edge_count,
  output logic o_transition
);
  typedef struct packed {
    logic [2:0] sector;
    logic valid;
    logic [15:0] mid;
    logic [15:0] edge_c;
    logic trans;
  } hall_st_t;
  hall_st_t s_r, s_nxt;
  logic [2:0] sec;
  logic [32:0] prod;
  logic [15:0] sixth;
  logic [15:0] base;
  logic fwd;

  // 120-degree hall code to sector, seven marks illegal
  function automatic logic [2:0] sector_of(input logic [2:0] h);
    unique case (h)
      3'h1: sector_of = 3'h0;
      3'h3: sector_of = 3'h1;
      3'h2: sector_of = 3'h2;
      3'h6: sector_of = 3'h3;
      3'h4: sector_of = 3'h4;
      3'h5: sector_of = 3'h5;
      default: sector_of = 3'h7;
    endcase
  endfunction : sector_of

  // boundaries assume exactly sixty degrees per sector
  always_comb begin
    sec = sector_of(i_hall);
    prod = {17'h0, i_mag_cycle} * {16'h0, axis_pkg::SIXTH_FRAC};
    sixth = prod[31:16];
    base = 16'(sixth * {13'h0, sec});
    fwd = (sec == 3'(s_r.sector + 3'h1)) ||
      (sec == 3'h0 && s_r.sector == 3'h5);
    s_nxt = s_r;
    s_nxt.valid = (sec != 3'h7);
    s_nxt.sector = sec;
    s_nxt.mid = 16'(base + (sixth >> 1));
    s_nxt.trans = s_r.valid && (sec != 3'h7) && (sec != s_r.sector);
    s_nxt.edge_c = fwd ? base : 16'(base + sixth);
  end

  // sector and estimates registered
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_valid = s_r.valid;
  assign o_mid_count = s_r.mid;
  assign o_edge_count = s_r.edge_c;
  assign o_transition = s_r.trans;
endmodule : hall_phase

//--- src/step_gen.sv
// step rate smoothing and square-wave step oscillator
// assumes i_tick is a one-cycle pulse from the parent profiler
`timescale 1ns/1ps
module step_gen (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [15:0] i_rate,
  input wire logic [4:0] i_smooth,
  output logic o_level,
  output logic o_step
);
  typedef struct packed {
    logic [23:0] rate_s;
    logic [16:0] acc;
    logic level;
    logic step;
  } step_st_t;
  step_st_t s_r, s_nxt;
  logic [23:0] tgt;
  logic [4:0] sh;
  logic [16:0] sum;

  // filtered rate, larger smoothing moves slower; toggle on carry
  always_comb begin
    tgt = {i_rate, 8'h00};
    sh = (i_smooth < axis_pkg::SMOOTH_MIN) ? axis_pkg::SMOOTH_MIN :
      (i_smooth > axis_pkg::SMOOTH_MAX) ? axis_pkg::SMOOTH_MAX : i_smooth;
    s_nxt = s_r;
    s_nxt.step = 1'b0;
    if (i_tick) begin
      if (tgt > s_r.rate_s) begin
        s_nxt.rate_s = s_r.rate_s + ((tgt - s_r.rate_s) >> sh);
      end else begin
        s_nxt.rate_s = s_r.rate_s - ((s_r.rate_s - tgt) >> sh);
      end
    end
    sum = {1'b0, s_r.acc[15:0]} + {1'b0, s_r.rate_s[23:8]};
    if (i_run) begin
      s_nxt.acc = sum;
      if (sum[16]) begin
        s_nxt.level = ~s_r.level;
        s_nxt.step = ~s_r.level;
      end
    end else begin
      s_nxt.acc = '0;
      s_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_level = s_r.level;
  assign o_step = s_r.step;

  // while running, each level flip comes from an accumulator carry only
  property p_duty;
    @(posedge i_clock) disable iff (!i_reset_n)
      (s_r.level != $past(s_r.level)) && $past(i_run) |->
        $past(sum[16]);
  endproperty
  a_duty: assert property (p_duty) else $error("step flip without carry");
endmodule : step_gen

//--- tb/motor_rig.sv
// motor rig: quadrature encoder and hall sensors of one axis
// assumes the bench pulses i_fwd no faster than once every 4 cycles
`timescale 1ns/1ps
module motor_rig #(
  parameter int CYCLE = 120
) (
  input wire logic i_clock,
  input wire logic i_fwd,
  output logic o_enc_a,
  output logic o_enc_b,
  output logic [2:0] o_hall
);
  int pos = 0;
  int sec;
  // one encoder count per pulse, never reset with the device
  always @(posedge i_clock) begin
    if (i_fwd) pos <= pos + 1;
  end
  // gray sequence on the two channels
  assign o_enc_a = pos[1];
  assign o_enc_b = pos[1] ^ pos[0];
  // six equal hall sectors per magnetic cycle
  always_comb begin
    sec = ((pos % CYCLE) * 6) / CYCLE;
    case (sec)
      0: o_hall = 3'h1;
      1: o_hall = 3'h3;
      2: o_hall = 3'h2;
      3: o_hall = 3'h6;
      4: o_hall = 3'h4;
      default: o_hall = 3'h5;
    endcase
  end
endmodule : motor_rig

//--- tb/tb_top.sv
// self-checking bench for one commutation and step axis
// assumes the rig model stands at the encoder and hall pins
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fwd = 1'b0;
  logic jumper = 1'b0;
  logic enc_a;
  logic enc_b;
  logic [2:0] hall;
  logic [31:0] rdata;
  logic [15:0] pcmd;
  logic [15:0] scmd;
  logic amp_en;
  logic aux_ok;
  logic [31:0] rv;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int hi;
  int lo;
  row_t rows [9];

  commutation_axis #(.ZP_CYCLES(16)) commutation_axis_inst (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .i_ADDR(addr), .i_WDATA(wdata),
    .i_WR(wr), .i_RD(rd), .i_ENC_A(enc_a), .i_ENC_B(enc_b),
    .i_HALL(hall), .i_MOTOR_OFF_JUMPER(jumper), .o_RDATA(rdata),
    .o_PRIMARY_CMD(pcmd), .o_SECONDARY_CMD(scmd),
    .o_AMP_ENABLE(amp_en), .o_AUX_ENC_AVAIL(aux_ok)
  );
  motor_rig #(.CYCLE(120)) motor_rig_inst (
    .i_clock(clk), .i_fwd(fwd), .o_enc_a(enc_a), .o_enc_b(enc_b),
    .o_hall(hall)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg

  // reset held 12 cycles, outputs checked while held
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    tick(12);
    check({pcmd, 15'h0, amp_en}, 32'h0);
    check({31'h0, aux_ok}, 32'h1);
    rst_n <= 1'b1;
    tick(8);
  endtask : do_reset

  initial begin
    rows[0] = '{1'b0, axis_pkg::A_MAG_CYCLE, 32'h0, 32'h0fa0};
    rows[1] = '{1'b0, axis_pkg::A_SMOOTH, 32'h0, 32'h2};
    rows[2] = '{1'b1, axis_pkg::A_SMOOTH, 32'h0, 32'h1};
    rows[3] = '{1'b1, axis_pkg::A_SMOOTH, 32'h1f, 32'h10};
    rows[4] = '{1'b1, axis_pkg::A_MOTOR_TYPE, 32'h2, 32'h2};
    rows[5] = '{1'b1, axis_pkg::A_MOTOR_TYPE, 32'hfe, 32'hfffffffe};
    rows[6] = '{1'b1, 8'h40, 32'h55, 32'h0};
    rows[7] = '{1'b1, axis_pkg::A_SLEW, 32'h1234, 32'h1234};
    rows[8] = '{1'b1, axis_pkg::A_STATUS, 32'hff, 32'h12};
    // boot: hall estimate and servo on
    do_reset();
    check({31'h0, amp_en}, 32'h1);
    rd_reg(axis_pkg::A_STATUS);
    check(rv, 32'h12);
    rd_reg(axis_pkg::A_PHASE);
    check({31'h0, rv != 32'h0 && rv < 32'd667}, 32'h1);
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      check(rv, rows[i].e);
    end
    $display("test boot and registers done");
    // jumper fitted: motor off, then zero-phase before enabling
    jumper = 1'b1;
    do_reset();
    check({31'h0, amp_en}, 32'h0);
    wr_reg(axis_pkg::A_ZERO_PHASE, 32'hfffe);
    tick(2);
    check({pcmd, 15'h0, amp_en}, 32'hfffe0001);
    wr_reg(axis_pkg::A_ZERO_PHASE, 32'h2);
    tick(24);
    rd_reg(axis_pkg::A_PHASE);
    check(rv, 32'h0);
    rd_reg(axis_pkg::A_STATUS);
    check(rv, 32'h12);
    rd_reg(axis_pkg::A_PHASE_OFS);
    check(rv, 32'h0);
    wr_reg(axis_pkg::A_ZERO_PHASE, 32'h2);
    tick(24);
    rd_reg(axis_pkg::A_STATUS);
    check(rv, 32'h10);
    jumper = 1'b0;
    $display("test zero phase done");
    // stepper: polarity, duty, direction, positions
    do_reset();
    wr_reg(axis_pkg::A_CTRL, 32'h1);
    wr_reg(axis_pkg::A_MOTOR_TYPE, 32'h2);
    tick(3);
    check({31'h0, aux_ok}, 32'h0);
    check({16'h0, pcmd}, 32'hffff);
    wr_reg(axis_pkg::A_MOTOR_TYPE, 32'hfe);
    tick(3);
    check({16'h0, pcmd}, 32'h0);
    wr_reg(axis_pkg::A_SMOOTH, 32'h1);
    // rate settles to an exact 16-cycle half period before measuring
    wr_reg(axis_pkg::A_SLEW, 32'h1001);
    wr_reg(axis_pkg::A_ACCEL, 32'hffff);
    wr_reg(axis_pkg::A_DECEL, 32'h1001);
    wr_reg(axis_pkg::A_TARGET, 32'hfffffc18);
    tick(24000);
    for (int k = 0; k < 300 && pcmd !== 16'h0; k++) tick(1);
    for (int k = 0; k < 300 && pcmd !== 16'hffff; k++) tick(1);
    hi = 0;
    lo = 0;
    while (pcmd === 16'hffff && hi < 300) begin
      hi++;
      tick(1);
    end
    while (pcmd === 16'h0 && lo < 300) begin
      lo++;
      tick(1);
    end
    check(32'(hi), 32'(lo));
    check({31'h0, hi > 0 && hi < 300}, 32'h1);
    check({16'h0, scmd}, 32'hffff);
    rd_reg(axis_pkg::A_POS_ERR);
    check(rv, 32'h0);
    rd_reg(axis_pkg::A_REF_POS);
    check({31'h0, rv[31]}, 32'h1);
    rd_reg(axis_pkg::A_ENC_POS);
    check(rv, 32'h0);
    $display("test stepper done");
    // hall calibration on the first transition
    do_reset();
    wr_reg(axis_pkg::A_MAG_CYCLE, 32'h78);
    wr_reg(axis_pkg::A_CTRL, 32'he);
    rd_reg(axis_pkg::A_STATUS);
    check({31'h0, rv[2]}, 32'h1);
    repeat (25) begin
      @(posedge clk);
      fwd <= 1'b1;
      @(posedge clk);
      fwd <= 1'b0;
      tick(3);
    end
    tick(8);
    rd_reg(axis_pkg::A_STATUS);
    check({31'h0, rv[2]}, 32'h0);
    rd_reg(axis_pkg::A_PHASE);
    check(rv, 32'd25);
    rd_reg(axis_pkg::A_ENC_POS);
    check(rv, 32'd25);
    $display("test calibration done");
    print_verdict();
  end
endmodule : tb_top
